/* File: verilog/flash_ctrl_pkg.sv */
// constants, types and helpers shared by the flash host controller
package flash_ctrl_pkg;

	// ==========
	// widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 16;
	localparam int SECTOR_LSB = 16;
	localparam int SECTOR_W = 6;
	localparam int PAGE_W = 5;

	// ==========
	// software register indices (word address)
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_WDATA = 3'h2;
	localparam logic [2:0] REG_COUNT = 3'h3;
	localparam logic [2:0] REG_STATUS = 3'h4;
	localparam logic [2:0] REG_RDATA = 3'h5;
	localparam logic [2:0] REG_BUFDATA = 3'h6;

	// status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_BYPASS = 4;
	localparam int ST_ERASING = 5;
	localparam int ST_SUSPENDED = 6;
	localparam int ST_READY = 7;

	// poll data bit positions
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_FLAG_ONE = 6;
	localparam int TIMEOUT_FLAG = 5;

	// ==========
	// flash bus codes, byte mode
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000aaa;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h000555;
	localparam logic [ADDR_W-1:0] ANY_ADDR = 22'h000000;
	localparam logic [ADDR_W-1:0] QUERY_ADDR = 22'h0000aa;
	localparam logic [ADDR_W-1:0] ID_OFS1 = 22'h000002;
	localparam logic [ADDR_W-1:0] ID_OFS2 = 22'h00001c;
	localparam logic [ADDR_W-1:0] ID_OFS3 = 22'h00001e;
	localparam logic [7:0] UNLOCK1_DATA = 8'haa;
	localparam logic [7:0] UNLOCK2_DATA = 8'h55;
	localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
	localparam logic [7:0] CMD_SECURE_ENTER = 8'h88;
	localparam logic [7:0] CMD_ZERO = 8'h00;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
	localparam logic [7:0] CMD_BUF_CONFIRM = 8'h29;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_QUERY = 8'h98;

	// ==========
	// bus cycle timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_SETUP_NS = 25;
	localparam int T_WE_LOW_NS = 35;
	localparam int T_HOLD_NS = 25;
	localparam int T_ACCESS_NS = 100;
	localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WE_LOW_CYC = 4'((T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========
	// operations that software may order
	typedef enum logic [4:0] {
		OP_READ = 5'h00, OP_RESET = 5'h01, OP_AUTOSEL = 5'h02, OP_DEVICE_ID = 5'h03,
		OP_SEC_ENTER = 5'h04, OP_SEC_EXIT = 5'h05, OP_PROGRAM = 5'h06, OP_BUF_PROGRAM = 5'h07,
		OP_ABORT_RESET = 5'h08, OP_BYPASS_ENTER = 5'h09, OP_BYPASS_PROGRAM = 5'h0a,
		OP_BYPASS_RESET = 5'h0b, OP_CHIP_ERASE = 5'h0c, OP_SECTOR_ERASE = 5'h0d,
		OP_SUSPEND = 5'h0e, OP_RESUME = 5'h0f, OP_QUERY = 5'h10, OP_WAIT_READY = 5'h11
	} op_type;

	typedef enum logic [1:0] {STEP_WRITE = 2'h0, STEP_READ = 2'h1, STEP_END = 2'h2} step_type;

	// base address of the sector holding a byte address
	function automatic logic [ADDR_W-1:0] sector_base(input logic [ADDR_W-1:0] a);
		sector_base = {a[SECTOR_LSB+SECTOR_W-1:SECTOR_LSB], 16'h0000};
	endfunction

endpackage

/* File: verilog/flash_seq_rom.sv */
// step table: bus cycle of each step of each flash command sequence
`timescale 1ns/1ps
`default_nettype none
module flash_seq_rom import flash_ctrl_pkg::*; (
	input wire op_type op_i,
	input wire logic [4:0] step_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [3:0] count_i,
	input wire logic [7:0] slot_data_i,
	output step_type kind_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [7:0] data_o
);
	logic [ADDR_W-1:0] sa;
	logic [4:0] slot_ofs;
	logic [4:0] last_slot;
	logic needs_unlock;

	// sector address and slot address inside the write-buffer page
	assign sa = sector_base(addr_i);
	assign slot_ofs = addr_i[PAGE_W-1:0] + {1'b0, step_i[3:0] - 4'h4};
	assign last_slot = 5'd4 + {1'b0, count_i};
	assign needs_unlock = op_i inside {OP_AUTOSEL, OP_DEVICE_ID, OP_SEC_ENTER, OP_SEC_EXIT, OP_PROGRAM,
		OP_BUF_PROGRAM, OP_ABORT_RESET, OP_BYPASS_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE}; // unlock-led orders

	// unlock cycles drive zeros above the low command bits
	always_comb begin
		kind_o = STEP_END;
		addr_o = ANY_ADDR;
		data_o = CMD_ZERO;
		if (step_i == 5'd0 && needs_unlock) begin
			kind_o = STEP_WRITE; // [R6]
			addr_o = UNLOCK1_ADDR;
			data_o = UNLOCK1_DATA;
		end else if (step_i == 5'd1 && needs_unlock) begin
			kind_o = STEP_WRITE; // [R6] [R7]
			addr_o = UNLOCK2_ADDR;
			data_o = UNLOCK2_DATA;
		end else begin
			unique case (op_i)
				OP_READ: if (step_i == 5'd0) begin
					kind_o = STEP_READ; // [R8]
					addr_o = addr_i;
				end
				OP_RESET, OP_SUSPEND, OP_RESUME, OP_QUERY: if (step_i == 5'd0) begin
					kind_o = STEP_WRITE; // [R9] [R19] [R20] [R21]
					addr_o = (op_i == OP_QUERY) ? QUERY_ADDR : ANY_ADDR;
					data_o = (op_i == OP_RESET) ? CMD_RESET : (op_i == OP_SUSPEND) ? CMD_SUSPEND :
						(op_i == OP_RESUME) ? CMD_RESUME : CMD_QUERY;
				end
				OP_AUTOSEL, OP_DEVICE_ID, OP_SEC_EXIT: begin
					kind_o = STEP_WRITE;
					addr_o = UNLOCK1_ADDR;
					data_o = CMD_AUTOSELECT;
					if (step_i == 5'd3 && op_i == OP_SEC_EXIT) begin
						addr_o = ANY_ADDR;
						data_o = CMD_ZERO;
					end else if (step_i == 5'd3) begin
						kind_o = STEP_READ; // [R10] [R11] [R12] [R13]
						addr_o = (op_i == OP_DEVICE_ID) ? ID_OFS1 : addr_i;
					end else if (op_i == OP_DEVICE_ID && step_i == 5'd4) begin
						kind_o = STEP_READ; // [R11]
						addr_o = ID_OFS2;
					end else if (op_i == OP_DEVICE_ID && step_i == 5'd5) begin
						kind_o = STEP_READ; // [R11]
						addr_o = ID_OFS3;
					end else if (step_i == ((op_i == OP_DEVICE_ID) ? 5'd6 : 5'd4) && op_i != OP_SEC_EXIT) begin
						addr_o = ANY_ADDR; // leave identification mode [R9]
						data_o = CMD_RESET;
					end else if (step_i != 5'd2) begin
						kind_o = STEP_END;
					end
				end
				OP_SEC_ENTER, OP_ABORT_RESET, OP_BYPASS_ENTER: if (step_i == 5'd2) begin
					kind_o = STEP_WRITE; // [R15] [R16]
					addr_o = UNLOCK1_ADDR;
					data_o = (op_i == OP_SEC_ENTER) ? CMD_SECURE_ENTER :
						(op_i == OP_ABORT_RESET) ? CMD_RESET : CMD_BYPASS;
				end
				OP_PROGRAM: if (step_i == 5'd2) begin
					kind_o = STEP_WRITE;
					addr_o = UNLOCK1_ADDR;
					data_o = CMD_PROGRAM;
				end else if (step_i == 5'd3) begin
					kind_o = STEP_WRITE;
					addr_o = addr_i;
					data_o = wdata_i;
				end
				OP_BUF_PROGRAM: begin
					kind_o = STEP_WRITE; // [R14]
					addr_o = sa;
					if (step_i == 5'd2) begin
						data_o = CMD_BUF_LOAD;
					end else if (step_i == 5'd3) begin
						data_o = {4'h0, count_i}; // locations minus one [R5]
					end else if (step_i <= last_slot) begin
						addr_o = {addr_i[ADDR_W-1:PAGE_W], slot_ofs}; // stays in the page [R4]
						data_o = slot_data_i;
					end else if (step_i == last_slot + 5'd1) begin
						data_o = CMD_BUF_CONFIRM;
					end else begin
						kind_o = STEP_END;
					end
				end
				OP_BYPASS_PROGRAM, OP_BYPASS_RESET: if (step_i <= 5'd1) begin
					kind_o = STEP_WRITE; // [R16] [R17]
					addr_o = (op_i == OP_BYPASS_PROGRAM && step_i == 5'd1) ? addr_i : ANY_ADDR;
					data_o = (op_i == OP_BYPASS_PROGRAM) ? ((step_i == 5'd0) ? CMD_PROGRAM : wdata_i) :
						((step_i == 5'd0) ? CMD_AUTOSELECT : CMD_ZERO);
				end
				OP_CHIP_ERASE, OP_SECTOR_ERASE: if (step_i <= 5'd5) begin
					kind_o = STEP_WRITE; // [R18]
					addr_o = UNLOCK1_ADDR;
					data_o = CMD_ERASE_SETUP;
					if (step_i == 5'd3) begin
						data_o = UNLOCK1_DATA;
					end else if (step_i == 5'd4) begin
						addr_o = UNLOCK2_ADDR;
						data_o = UNLOCK2_DATA;
					end else if (step_i == 5'd5) begin
						addr_o = (op_i == OP_SECTOR_ERASE) ? sa : UNLOCK1_ADDR; // [R3]
						data_o = (op_i == OP_SECTOR_ERASE) ? CMD_SECTOR_ERASE : CMD_CHIP_ERASE;
					end
				end
				default: kind_o = STEP_END;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: verilog/flash_bus_cycle.sv */
// one asynchronous flash bus cycle, write or read, on the pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle import flash_ctrl_pkg::*; (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic start_i,
	input wire logic is_read_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] dq_i,
	output logic ce_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [7:0] dq_o,
	output logic dq_oe_o,
	output logic [7:0] rdata_o,
	output logic done_o
);
	typedef enum logic [1:0] {CYC_IDLE = 2'b00, CYC_SETUP = 2'b01, CYC_STROBE = 2'b11, CYC_HOLD = 2'b10} cyc_type;
	typedef struct packed {
		cyc_type st;
		logic [3:0] cnt;
		logic rd;
		logic ce_n, we_n, oe_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0] dq;
		logic dq_oe;
		logic [7:0] rdata;
		logic done;
	} cyc_state_type;
	cyc_state_type q, d;

	// ce falls first, strobe later, strobe rises before ce
	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			CYC_IDLE: if (start_i) begin
				d.st = CYC_SETUP;
				d.cnt = SETUP_CYC;
				d.rd = is_read_i;
				d.ce_n = 1'b0;
				d.addr = addr_i;
				d.dq = data_i;
				d.dq_oe = !is_read_i;
			end
			CYC_SETUP: if (q.cnt == 4'h1) begin
				d.st = CYC_STROBE;
				d.cnt = q.rd ? ACCESS_CYC : WE_LOW_CYC;
				d.we_n = q.rd; // address taken at this later falling edge [R1]
				d.oe_n = !q.rd;
			end else begin
				d.cnt = q.cnt - 4'h1;
			end
			CYC_STROBE: if (q.cnt == 4'h1) begin
				d.st = CYC_HOLD;
				d.cnt = HOLD_CYC;
				d.we_n = 1'b1; // data taken as write strobe rises ahead of ce [R2]
				d.oe_n = 1'b1;
				if (q.rd) begin
					d.rdata = dq_i;
				end
			end else begin
				d.cnt = q.cnt - 4'h1;
			end
			CYC_HOLD: if (q.cnt == 4'h1) begin
				d.st = CYC_IDLE;
				d.ce_n = 1'b1;
				d.dq_oe = 1'b0;
				d.done = 1'b1;
			end else begin
				d.cnt = q.cnt - 4'h1;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '{st: CYC_IDLE, cnt: 4'h0, rd: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
				addr: 22'h000000, dq: 8'h00, dq_oe: 1'b0, rdata: 8'h00, done: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign ce_n_o = q.ce_n;
	assign we_n_o = q.we_n;
	assign oe_n_o = q.oe_n;
	assign addr_o = q.addr;
	assign dq_o = q.dq;
	assign dq_oe_o = q.dq_oe;
	assign rdata_o = q.rdata;
	assign done_o = q.done;
endmodule
`default_nettype wire

/* File: verilog/flash_host_ctrl.sv */
// host controller for a parallel flash in byte mode, ordered over Avalon-MM
// Operation
// [R1] address is latched on the later falling edge of write strobe or chip select
// [R2] data is latched on the earlier rising edge of write strobe or chip select
// [R3] sector is chosen by address bits A20 to A15, one sector each
// [R4] every buffer location lies in the write-buffer page of the first address
// [R5] buffer count written is number of locations minus one
// [R6] unlock writes AA to AAA then 55 to 555; upper bits ignored
// [R7] address bits A20 to A11 are don't care in command cycles
// [R8] plain reads in read mode need no unlock or command cycles
// [R9] F0 to any address leaves identification mode or clears timeout failure
// [R10] after three writes ending 90 the fourth cycle is a read
// [R11] maker code at X00, device identifier read at X02, X1C, X1E
// [R12] secure-region protect status reads 98h, 18h, 88h or 08h
// [R13] group protect verify at sector offset X04 reads 00h or 01h
// [R14] buffered program: unlock, 25, count, pairs, 29 confirm, at most 21 cycles
// [R15] aborted buffer program is cleared by unlock, unlock, F0
// [R16] bypass program only after bypass entry ending in data 20
// [R17] bypass mode left only by 90 then 00 to any address
// [R18] erase is six cycles ending 10 to AAA or 30 to a sector
// [R19] suspend B0 only during sector erase; then reads, programs, identification allowed
// [R20] resume 30 acts only in erase-suspend mode
// [R21] query 98 to AA only when reading array or in identification mode
// [R22] progress shown on status data bits and a ready/busy pin
// [R23] during program, poll bit reads inverted, true once complete
// [R24] toggle flag one flips each read while busy, stops at the end
// [R25] a mismatched write cycle abandons a partial command sequence
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl import flash_ctrl_pkg::*; #(
	parameter int POLL_LIMIT = 1000000
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [2:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic flash_ce_n_o,
	output logic flash_we_n_o,
	output logic flash_oe_n_o,
	output logic [ADDR_W-1:0] flash_addr_o,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [7:0] flash_dq_i,
	input wire logic ready_busy_pin_i
);
	// ==========
	// state
	typedef enum logic [2:0] {M_IDLE = 3'b000, M_FETCH = 3'b001, M_WAIT = 3'b011,
		M_POLL = 3'b010, M_PWAIT = 3'b110} mstate_type;
	typedef struct packed {
		mstate_type st;
		logic waitreq;
		logic [31:0] rbus;
		op_type op;
		logic [4:0] step;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [3:0] count;
		logic [BUF_DEPTH-1:0][7:0] slot;
		logic [3:0] load_idx;
		logic [23:0] rd;
		logic busy, done, fail, refused;
		logic bypass, erasing, sector_erase, suspended;
		logic start;
		logic [7:0] prev;
		logic have_prev, dq5_seen;
		logic [23:0] poll_cnt;
	} host_state_type;
	host_state_type q, d;

	step_type kind;
	logic [ADDR_W-1:0] step_addr;
	logic [7:0] step_data;
	logic [7:0] eng_rdata;
	logic eng_done;
	logic [3:0] slot_idx;

	// true when an order may not be sent in the present mode
	function automatic logic op_refused(input op_type op, input logic byp, input logic ers,
			input logic sect, input logic susp);
		logic r;
		r = 1'b0;
		if (byp) begin
			r = !(op inside {OP_READ, OP_BYPASS_PROGRAM, OP_BYPASS_RESET}); // [R17]
		end else if (op inside {OP_BYPASS_PROGRAM, OP_BYPASS_RESET}) begin
			r = 1'b1; // [R16]
		end else if (op == OP_SUSPEND) begin
			r = !(ers && sect); // [R19]
		end else if (op == OP_RESUME) begin
			r = !susp; // [R20]
		end else if (ers) begin
			r = !(op inside {OP_READ, OP_WAIT_READY});
		end else if (susp) begin
			r = !(op inside {OP_READ, OP_RESET, OP_PROGRAM, OP_AUTOSEL, OP_DEVICE_ID}); // [R19] [R21]
		end
		r = r || (op > OP_WAIT_READY); // codes past the last order
		op_refused = r;
	endfunction

	// operations that wait for the embedded algorithm to end
	function automatic logic op_polls(input op_type op);
		op_polls = op inside {OP_PROGRAM, OP_BUF_PROGRAM, OP_BYPASS_PROGRAM, OP_WAIT_READY};
	endfunction

	// ==========
	// step table and pin engine
	assign slot_idx = q.step[3:0] - 4'h4;

	flash_seq_rom u_rom (
		.op_i(q.op),
		.step_i(q.step),
		.addr_i(q.addr),
		.wdata_i(q.wdata),
		.count_i(q.count),
		.slot_data_i(q.slot[slot_idx]),
		.kind_o(kind),
		.addr_o(step_addr),
		.data_o(step_data)
	);

	flash_bus_cycle u_cyc (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.start_i(q.start),
		.is_read_i((q.st == M_PWAIT) || (kind == STEP_READ)),
		.addr_i((q.st == M_PWAIT) ? q.addr : step_addr),
		.data_i(step_data),
		.dq_i(flash_dq_i),
		.ce_n_o(flash_ce_n_o),
		.we_n_o(flash_we_n_o),
		.oe_n_o(flash_oe_n_o),
		.addr_o(flash_addr_o),
		.dq_o(flash_dq_o),
		.dq_oe_o(flash_dq_oe_o),
		.rdata_o(eng_rdata),
		.done_o(eng_done)
	);

	// ==========
	// next state: register slave, then sequencer
	always_comb begin
		d = q;
		d.start = 1'b0;
		d.waitreq = 1'b1;

		// one wait cycle, then answer; writes act at the answering edge
		if ((avs_read_i || avs_write_i) && q.waitreq) begin
			d.waitreq = 1'b0;
			unique case (avs_address_i)
				REG_CTRL: d.rbus = {27'h0, q.op};
				REG_ADDR: d.rbus = {10'h0, q.addr};
				REG_WDATA: d.rbus = {24'h0, q.wdata};
				REG_COUNT: d.rbus = {24'h0, q.load_idx, q.count};
				REG_STATUS: d.rbus = {24'h0, ready_busy_pin_i, q.suspended, q.erasing, q.bypass,
					q.refused, q.fail, q.done, q.busy}; // [R22]
				REG_RDATA: d.rbus = {8'h0, q.rd};
				default: d.rbus = 32'h0;
			endcase
		end
		if (avs_write_i && !q.waitreq) begin
			unique case (avs_address_i)
				REG_CTRL: if (q.busy || op_refused(op_type'(avs_writedata_i[4:0]), q.bypass, q.erasing,
						q.sector_erase, q.suspended)) begin
					d.refused = 1'b1;
				end else begin
					d.op = op_type'(avs_writedata_i[4:0]);
					d.busy = 1'b1;
					d.step = 5'd0;
					d.st = M_FETCH;
					d.have_prev = 1'b0;
					d.dq5_seen = 1'b0;
					d.poll_cnt = 24'h0;
				end
				REG_ADDR: d.addr = avs_writedata_i[ADDR_W-1:0];
				REG_WDATA: d.wdata = avs_writedata_i[7:0];
				REG_COUNT: begin
					d.count = avs_writedata_i[3:0]; // [R5]
					d.load_idx = 4'h0;
				end
				REG_STATUS: begin
					d.done = q.done && !avs_writedata_i[ST_DONE];
					d.fail = q.fail && !avs_writedata_i[ST_FAIL];
					d.refused = q.refused && !avs_writedata_i[ST_REFUSED];
				end
				REG_BUFDATA: if (!q.busy) begin
					d.slot[q.load_idx] = avs_writedata_i[7:0];
					d.load_idx = q.load_idx + 4'h1;
				end
				default: d.rbus = q.rbus;
			endcase
		end

		// sequencer; its flag sets come after the clears above
		unique case (q.st)
			M_IDLE: d.busy = d.busy && (d.st != M_IDLE); // keep an order taken this cycle
			M_FETCH: if (kind == STEP_END) begin
				if (op_polls(q.op) && !q.fail) begin
					d.st = M_POLL;
				end else begin
					d.st = M_IDLE;
					d.busy = 1'b0;
					d.done = 1'b1;
					unique case (q.op)
						OP_BYPASS_ENTER: d.bypass = 1'b1; // [R16]
						OP_BYPASS_RESET: d.bypass = 1'b0; // [R17]
						OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
							d.erasing = 1'b1; // [R18]
							d.sector_erase = (q.op == OP_SECTOR_ERASE);
						end
						OP_SUSPEND: begin
							d.erasing = 1'b0; // [R19]
							d.suspended = 1'b1;
						end
						OP_RESUME: begin
							d.erasing = 1'b1; // [R20]
							d.suspended = 1'b0;
						end
						OP_BUF_PROGRAM: d.load_idx = 4'h0;
						default: d.done = 1'b1;
					endcase
				end
			end else begin
				d.start = 1'b1;
				d.st = M_WAIT;
			end
			M_WAIT: if (eng_done) begin
				if (kind == STEP_READ) begin
					d.rd = {q.rd[15:0], eng_rdata}; // [R10] [R11]
				end
				d.step = q.step + 5'd1;
				d.st = M_FETCH;
			end
			M_POLL: begin
				d.start = 1'b1;
				d.st = M_PWAIT;
			end
			M_PWAIT: if (eng_done) begin
				d.rd = {16'h0, eng_rdata};
				d.prev = eng_rdata;
				d.st = M_POLL;
				if (!q.have_prev) begin
					d.have_prev = 1'b1;
				end else if (q.prev[TOGGLE_FLAG_ONE] == eng_rdata[TOGGLE_FLAG_ONE] && ready_busy_pin_i) begin
					d.st = M_IDLE; // toggling stopped [R24] [R22]
					d.busy = 1'b0;
					d.done = 1'b1;
					if (q.op == OP_WAIT_READY) begin
						d.erasing = 1'b0;
					end
					if (q.op != OP_WAIT_READY && eng_rdata[POLL_BIT] !=
							((q.op == OP_BUF_PROGRAM) ? q.slot[0][POLL_BIT] : q.wdata[POLL_BIT])) begin
						d.fail = 1'b1; // true value expected on completion [R23]
					end
					if (q.op == OP_BUF_PROGRAM) begin
						d.load_idx = 4'h0;
					end
				end else if (q.dq5_seen || q.poll_cnt == 24'(POLL_LIMIT)) begin
					d.fail = 1'b1; // still toggling after timeout: send F0 [R9]
					d.erasing = 1'b0;
					d.op = OP_RESET;
					d.step = 5'd0;
					d.st = M_FETCH;
				end else begin
					d.dq5_seen = eng_rdata[TIMEOUT_FLAG]; // recheck once after the timeout flag [R22]
					d.poll_cnt = q.poll_cnt + 24'h1;
				end
			end
			default: d.st = M_IDLE;
		endcase
	end

	// ==========
	// state register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.waitreq <= 1'b1;
			q.st <= M_IDLE;
			q.op <= OP_READ;
		end else begin
			q <= d;
		end
	end

	assign avs_readdata_o = q.rbus;
	assign avs_waitrequest_o = q.waitreq;
endmodule
`default_nettype wire

/* File: bench/flash_host_ctrl_asserts.sv */
// checker on the flash host controller ports
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_asserts import flash_ctrl_pkg::*; (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic flash_ce_n_o,
	input wire logic flash_we_n_o,
	input wire logic flash_oe_n_o,
	input wire logic [ADDR_W-1:0] flash_addr_o,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_dq_oe_o
);
	// ==========
	// strobe shapes and bus answers
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_we_pulse; !flash_we_n_o [*2] ##1 flash_we_n_o; endsequence
	sequence s_oe_pulse; !flash_oe_n_o [*4] ##1 flash_oe_n_o; endsequence
	property p_ack_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("long ack");
	property p_req_ack; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o; endproperty
	a_req_ack: assert property (p_req_ack) else $error("late ack");
	property p_addr_hold; !flash_we_n_o |-> $stable(flash_addr_o); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved");
	property p_data_hold; !flash_we_n_o || $rose(flash_we_n_o) |-> $stable(flash_dq_o) && flash_dq_oe_o; endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved");
	property p_we_pulse; $fell(flash_we_n_o) |-> !flash_ce_n_o throughout s_we_pulse; endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe shape");
	property p_rd_pulse; $fell(flash_oe_n_o) |-> (!flash_dq_oe_o && flash_we_n_o) throughout s_oe_pulse; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe shape");
	property p_unlock_hi; !flash_we_n_o && flash_dq_o == 8'h55 && flash_addr_o[11:0] == 12'h555 |->
		flash_addr_o[21:12] == 10'h0; endproperty
	a_unlock_hi: assert property (p_unlock_hi) else $error("unlock upper bits");
	property p_ce_gap; $rose(flash_ce_n_o) |=> flash_ce_n_o; endproperty
	a_ce_gap: assert property (p_ce_gap) else $error("short ce gap");
endmodule
bind flash_host_ctrl flash_host_ctrl_asserts chk_i (.clk_i(clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .flash_ce_n_o(flash_ce_n_o),
	.flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_addr_o(flash_addr_o),
	.flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire

/* File: bench/flash_dev_model.sv */
// behavioural byte-mode flash device driven by strobe edges
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model import flash_ctrl_pkg::*; #(
	parameter logic [7:0] MAKER_CODE = 8'h5a // arbitrary value
) (
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic ready_busy_pin_o
);
	logic [7:0] mem [256];
	logic [7:0] pv = 8'h00, v, lastv = 8'h00;
	logic [ADDR_W-1:0] a = '0;
	logic [1:0] u = 2'h0;
	logic auto_q = 1'b0, pgm = 1'b0, tog = 1'b0;
	int busy = 0;
	wire wr_n = we_n_i | ce_n_i;
	wire rd_n = oe_n_i | ce_n_i;
	// ==========
	// erased array at start
	initial foreach (mem[i]) mem[i] = 8'hff;
	// address on the later falling edge, data on the earlier rising edge
	always @(negedge wr_n) a = addr_i;
	always @(posedge wr_n) begin
		if (pgm) begin
			mem[a[7:0]] = dq_i;
			pv = dq_i;
			busy = 3;
			pgm = 1'b0;
		end else if (dq_i == 8'hf0) begin
			auto_q = 1'b0;
			u = 2'h0;
		end else if (u == 2'h0 && a[11:0] == 12'haaa && dq_i == 8'haa) u = 2'h1;
		else if (u == 2'h1 && a[11:0] == 12'h555 && dq_i == 8'h55) u = 2'h2;
		else if (u == 2'h2 && dq_i == 8'h90) {auto_q, u} = 3'h4;
		else if (u == 2'h2 && dq_i == 8'ha0) {pgm, u} = 3'h4;
		else u = 2'h0;
	end
	// status while busy; in identification maker code at 00, 18h at 06, else 00; array otherwise
	assign v = busy > 0 ? {~pv[7], tog, 6'h00} : !auto_q ? mem[addr_i[7:0]] : addr_i[7:0] == 8'h00 ? MAKER_CODE :
		addr_i[7:0] == 8'h06 ? 8'h18 : 8'h00;
	always @(negedge rd_n) tog = ~tog;
	always @(posedge rd_n) begin
		lastv = v;
		if (busy > 0) busy = busy - 1;
	end
	// released bus shows the inverse of the last byte
	assign dq_o = rd_n ? ~lastv : v;
	assign ready_busy_pin_o = busy == 0;
endmodule
`default_nettype wire

/* File: bench/test_flash_host_ctrl.sv */
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_host_ctrl import flash_ctrl_pkg::*;;
	localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
	logic clk_i = 1'b0, srst_i = 1'b1, rd_q = 1'b0, wr_q = 1'b0, chk_q = 1'b0;
	logic [2:0] ad_q = 3'h0;
	logic [31:0] wd_q = 32'h0, rdata, eq[$], mq[$];
	logic wait_o, ce_n, we_n, oe_n, dq_oe, rb;
	logic [ADDR_W-1:0] fa;
	logic [7:0] hdq, mdq, fdq;
	int errors = 0, n_checks = 0, cyc = 0;
	assign fdq = dq_oe ? hdq : mdq;
	always #12.5 clk_i = ~clk_i;
	flash_host_ctrl #(.POLL_LIMIT(20)) uut (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(ad_q),
		.avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wd_q), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n),
		.flash_addr_o(fa), .flash_dq_o(hdq), .flash_dq_oe_o(dq_oe), .flash_dq_i(fdq), .ready_busy_pin_i(rb));
	flash_dev_model #(.MAKER_CODE(MAKER)) dev (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(fa),
		.dq_i(fdq), .dq_o(mdq), .ready_busy_pin_o(rb));
	// ==========
	// comparison and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch register read expected %h seen %h", exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// one Avalon access held until waitrequest low
	task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic [31:0] m, input logic c, output logic [31:0] r);
		if (c) begin
			eq.push_back(e);
			mq.push_back(m);
		end
		{ad_q, rd_q, wr_q, wd_q, chk_q} <= {a, !w, w, d, c};
		@(posedge clk_i);
		while (wait_o !== 1'b0) @(posedge clk_i);
		r = rdata;
		{rd_q, wr_q, chk_q} <= 3'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] r;
		av(1'b1, a, d, 32'h0, 32'h0, 1'b0, r);
	endtask
	task automatic rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] r;
		av(1'b0, a, 32'h0, e, m, 1'b1, r);
	endtask
	// start an operation and poll status until done or refused
	task automatic op(input logic [4:0] o, input logic [7:0] pa, input logic [7:0] d);
		logic [31:0] r;
		wr(REG_STATUS, 32'he);
		wr(REG_ADDR, {24'h0, pa});
		wr(REG_WDATA, {24'h0, d});
		wr(REG_CTRL, {27'h0, o});
		r = 32'h0;
		while (r[ST_DONE] !== 1'b1 && r[ST_REFUSED] !== 1'b1) av(1'b0, REG_STATUS, 0, 0, 0, 1'b0, r);
	endtask
	// watcher: compares each checked read with the oldest note, and cuts a hang
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 40000) begin
			errors++;
			complete_run();
		end
		if (rd_q && wait_o === 1'b0 && chk_q && eq.size() > 0) chk(rdata & mq.pop_front(), eq.pop_front());
	end
	// main sequence
	initial begin
		logic [7:0] pa, pd;
		logic [4:0] ops [5] = '{5'h1f, OP_SUSPEND, OP_RESUME, OP_QUERY, OP_RESET};
		void'($urandom(76));
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		rd(3'h7, 32'h0, 32'hffffffff);
		for (int i = 0; i < 4; i++) begin
			pa = 8'($urandom);
			pd = 8'($urandom);
			op(OP_PROGRAM, pa, pd);
			rd(REG_STATUS, 32'h82, 32'h8f);
			op(OP_READ, pa, 8'h00);
			rd(REG_RDATA, {24'h0, pd}, 32'hff);
		end
		op(OP_AUTOSEL, 8'h00, 8'h00);
		rd(REG_RDATA, {24'h0, MAKER}, 32'hff);
		op(OP_AUTOSEL, 8'h06, 8'h00);
		rd(REG_RDATA, 32'h18, 32'hff);
		op(OP_AUTOSEL, 8'h04, 8'h00);
		rd(REG_RDATA, 32'h00, 32'hff);
		op(OP_READ, pa, 8'h00);
		rd(REG_RDATA, {24'h0, pd}, 32'hff);
		foreach (ops[i]) begin
			op(ops[i], 8'h00, 8'h00);
			rd(REG_STATUS, (i < 3) ? 32'h08 : 32'h02, 32'h0f);
		end
		complete_run();
	end
endmodule
`default_nettype wire
